// ---- verilog/semh_defines.svh ----
`ifndef SEMH_DEFINES_SVH
`define SEMH_DEFINES_SVH

// clock period and pin timing, times in ns
`define SEMH_CLK_NS       8
`define SEMH_T_SETUP_NS   10
`define SEMH_T_PULSE_NS   40
`define SEMH_T_RECOV_NS   16

// cycle counts, least times rounded up
`define SEMH_SETUP_CYC ((`SEMH_T_SETUP_NS + `SEMH_CLK_NS - 1) / `SEMH_CLK_NS)
`define SEMH_PULSE_CYC ((`SEMH_T_PULSE_NS + `SEMH_CLK_NS - 1) / `SEMH_CLK_NS)
`define SEMH_RECOV_CYC ((`SEMH_T_RECOV_NS + `SEMH_CLK_NS - 1) / `SEMH_CLK_NS)

// token space and data bus
`define SEMH_NUM_TOKENS   8
`define SEMH_FIRST_IDX    3'h0
`define SEMH_LAST_IDX     3'h7
`define SEMH_DQ_W         16
`define SEMH_FLAG_BIT     0
`define SEMH_DQ_ZEROS     16'h0000
`define SEMH_DQ_ONES      16'hffff

// failed-request polling budget
`define SEMH_POLL_MAX     4'hf
`define SEMH_POLL_RST     4'h0

`endif

// ---- verilog/semh_pkg.sv ----
package semh_pkg;

    // user command codes
    typedef enum logic [1:0] {
        SEMH_OP_ACQ  = 2'h0,
        SEMH_OP_REL  = 2'h1,
        SEMH_OP_READ = 2'h2,
        SEMH_OP_INIT = 2'h3
    } semh_op_t;

    // pin sequencer states, gray along idle-setup-active-recover
    typedef enum logic [1:0] {
        SEMH_AS_IDLE  = 2'h0,
        SEMH_AS_SETUP = 2'h1,
        SEMH_AS_ACT   = 2'h3,
        SEMH_AS_RECOV = 2'h2
    } semh_acc_st_t;

    // command states, gray along init-idle-acquire-withdraw-release-read
    typedef enum logic [2:0] {
        SEMH_ST_INIT  = 3'h0,
        SEMH_ST_IDLE  = 3'h1,
        SEMH_ST_ACQW  = 3'h3,
        SEMH_ST_ACQR  = 3'h2,
        SEMH_ST_WDRAW = 3'h6,
        SEMH_ST_RELW  = 3'h7,
        SEMH_ST_RD    = 3'h5
    } semh_st_t;

endpackage

// ---- verilog/semh_acc_if.sv ----
`include "semh_defines.svh"

// one semaphore access between command logic and pin sequencer
interface semh_acc_if;
    logic                     start;
    logic                     write;
    logic                     wbit;
    logic [2:0]               idx;
    logic                     done;
    logic [`SEMH_DQ_W-1:0]    rdata;

    modport ctrl (output start, output write, output wbit, output idx,
                  input done, input rdata);
    modport seq  (input start, input write, input wbit, input idx,
                  output done, output rdata);
endinterface

// ---- verilog/semh_pin_seq.sv ----
`include "semh_defines.svh"

module semh_pin_seq (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    semh_acc_if.seq                    acc,
    output logic                       semaphore_select_n,
    output logic                       ce_n,
    output logic                       rw_n,
    output logic                       oe_n,
    output logic [2:0]                 addr,
    input  wire logic [`SEMH_DQ_W-1:0] dq_i,
    output logic [`SEMH_DQ_W-1:0]      dq_o,
    output logic                       dq_oe_n
);
    localparam logic [2:0] SETUP_CNT = 3'(`SEMH_SETUP_CYC - 1);
    localparam logic [2:0] PULSE_CNT = 3'(`SEMH_PULSE_CYC - 1);
    localparam logic [2:0] RECOV_CNT = 3'(`SEMH_RECOV_CYC - 1);

    semh_pkg::semh_acc_st_t    st_r, st_nxt;
    logic [2:0]                cnt_r, cnt_nxt;
    logic                      wr_r, wr_nxt;
    logic                      sel_n_r, sel_n_nxt;
    logic                      rw_n_r, rw_n_nxt;
    logic                      oe_n_r, oe_n_nxt;
    logic                      ce_n_r;
    logic [2:0]                addr_r, addr_nxt;
    logic [`SEMH_DQ_W-1:0]     dq_o_r, dq_o_nxt;
    logic                      dq_oe_n_r, dq_oe_n_nxt;
    logic [`SEMH_DQ_W-1:0]     rdata_r, rdata_nxt;
    logic                      done_r, done_nxt;
    logic [`SEMH_DQ_W-1:0]     sync1_r, sync2_r;

    // next pin values; the read sample waits out the synchroniser
    always_comb begin
        st_nxt      = st_r;
        cnt_nxt     = cnt_r;
        wr_nxt      = wr_r;
        sel_n_nxt   = sel_n_r;
        rw_n_nxt    = rw_n_r;
        oe_n_nxt    = oe_n_r;
        addr_nxt    = addr_r;
        dq_o_nxt    = dq_o_r;
        dq_oe_n_nxt = dq_oe_n_r;
        rdata_nxt   = rdata_r;
        done_nxt    = 1'b0;
        case (st_r)
            semh_pkg::SEMH_AS_IDLE: begin
                if (acc.start) begin
                    addr_nxt    = acc.idx;
                    wr_nxt      = acc.write;
                    dq_o_nxt    = {`SEMH_DQ_W{acc.wbit}};
                    dq_oe_n_nxt = ~acc.write;
                    cnt_nxt     = SETUP_CNT;
                    st_nxt      = semh_pkg::SEMH_AS_SETUP;
                end
            end
            semh_pkg::SEMH_AS_SETUP: begin
                if (cnt_r == 3'h0) begin
                    sel_n_nxt = 1'b0;
                    rw_n_nxt  = ~wr_r;
                    oe_n_nxt  = wr_r;
                    cnt_nxt   = PULSE_CNT;
                    st_nxt    = semh_pkg::SEMH_AS_ACT;
                end else begin
                    cnt_nxt = 3'(cnt_r - 3'h1);
                end
            end
            semh_pkg::SEMH_AS_ACT: begin
                if (cnt_r == 3'h0) begin
                    if (!wr_r) begin
                        rdata_nxt = sync2_r;
                    end
                    // drop select and enables together: fresh capture
                    sel_n_nxt = 1'b1;
                    rw_n_nxt  = 1'b1;
                    oe_n_nxt  = 1'b1;
                    cnt_nxt   = RECOV_CNT;
                    st_nxt    = semh_pkg::SEMH_AS_RECOV;
                end else begin
                    cnt_nxt = 3'(cnt_r - 3'h1);
                end
            end
            semh_pkg::SEMH_AS_RECOV: begin
                if (cnt_r == 3'h0) begin
                    dq_oe_n_nxt = 1'b1;   // data held past strobe for hold
                    done_nxt    = 1'b1;
                    st_nxt      = semh_pkg::SEMH_AS_IDLE;
                end else begin
                    cnt_nxt = 3'(cnt_r - 3'h1);
                end
            end
            default: begin
                sel_n_nxt   = 1'b1;
                rw_n_nxt    = 1'b1;
                oe_n_nxt    = 1'b1;
                dq_oe_n_nxt = 1'b1;
                st_nxt      = semh_pkg::SEMH_AS_IDLE;
            end
        endcase
    end

    // registers; the ram select stays off for every access
    always_ff @(posedge mclk) begin
        sync1_r <= dq_i;
        sync2_r <= sync1_r;
        ce_n_r  <= 1'b1;
        if (srst) begin
            st_r      <= semh_pkg::SEMH_AS_IDLE;
            cnt_r     <= 3'h0;
            wr_r      <= 1'b0;
            sel_n_r   <= 1'b1;
            rw_n_r    <= 1'b1;
            oe_n_r    <= 1'b1;
            addr_r    <= `SEMH_FIRST_IDX;
            dq_o_r    <= `SEMH_DQ_ONES;
            dq_oe_n_r <= 1'b1;
            rdata_r   <= `SEMH_DQ_ONES;
            done_r    <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            wr_r      <= wr_nxt;
            sel_n_r   <= sel_n_nxt;
            rw_n_r    <= rw_n_nxt;
            oe_n_r    <= oe_n_nxt;
            addr_r    <= addr_nxt;
            dq_o_r    <= dq_o_nxt;
            dq_oe_n_r <= dq_oe_n_nxt;
            rdata_r   <= rdata_nxt;
            done_r    <= done_nxt;
        end
    end

    assign acc.done  = done_r;
    assign acc.rdata = rdata_r;
    assign semaphore_select_n = sel_n_r;
    assign ce_n      = ce_n_r;
    assign rw_n      = rw_n_r;
    assign oe_n      = oe_n_r;
    assign addr      = addr_r;
    assign dq_o      = dq_o_r;
    assign dq_oe_n   = dq_oe_n_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    strobe_in_sel_a: assert property (
        !rw_n_r |-> !sel_n_r && !dq_oe_n_r)
        else $error("write strobe outside semaphore select or data off");
    no_contention_a: assert property (
        !(!oe_n_r && !dq_oe_n_r))
        else $error("host drives data while device output enabled");
    read_gap_a: assert property (
        $rose(oe_n_r) |-> oe_n_r [*2])
        else $error("output enable gap between reads too short");
    addr_stable_a: assert property (
        !sel_n_r && !$past(sel_n_r) |-> $stable(addr_r))
        else $error("address moved during semaphore access");
endmodule // semh_pin_seq

// ---- verilog/semh_ctrl.sv ----
// Functional notes
// - zero written requests a token, one from same port releases it.
// - semaphore select low chooses token space, then sram-like access.
// - between polling reads, select or output enable must go high.
// - acquire by writing zero first, then reading back.
// - after a failed request keep reading or write one to withdraw.
// - at power-up write one to all eight tokens.
// - ram chip enable stays inactive during token access.
`include "semh_defines.svh"

module semh_ctrl (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic                  cmd_valid,
    input  semh_pkg::semh_op_t         cmd_op,
    input  wire logic [2:0]            cmd_idx,
    input  wire logic                  cmd_poll,
    output logic                       cmd_ready,
    output logic                       rsp_valid,
    output logic                       rsp_owned,
    output logic                       rsp_flag,
    output logic                       semaphore_select_n,
    output logic                       ce_n,
    output logic                       rw_n,
    output logic                       oe_n,
    output logic [2:0]                 addr,
    input  wire logic [`SEMH_DQ_W-1:0] dq_i,
    output logic [`SEMH_DQ_W-1:0]      dq_o,
    output logic                       dq_oe_n
);
    semh_acc_if acc ();

    semh_pkg::semh_st_t   st_r, st_nxt;
    semh_pkg::semh_op_t   op_r, op_nxt;
    logic                 busy_r, busy_nxt;
    logic                 start_r, start_nxt;
    logic                 write_r, write_nxt;
    logic                 wbit_r, wbit_nxt;
    logic [2:0]           idx_r, idx_nxt;
    logic [3:0]           polls_r, polls_nxt;
    logic                 poll_en_r, poll_en_nxt;
    logic                 ready_r, ready_nxt;
    logic                 rsp_valid_r, rsp_valid_nxt;
    logic                 rsp_owned_r, rsp_owned_nxt;
    logic                 rsp_flag_r, rsp_flag_nxt;
    logic                 init_done_r, init_done_nxt;
    logic                 won;

    // a read of all zeros means this port holds the token
    assign won = (acc.rdata == `SEMH_DQ_ZEROS);

    // command sequencing; each state but idle issues one access at a time, waiting for done before the next
    always_comb begin
        st_nxt        = st_r;
        op_nxt        = op_r;
        busy_nxt      = busy_r;
        start_nxt     = 1'b0;
        write_nxt     = write_r;
        wbit_nxt      = wbit_r;
        idx_nxt       = idx_r;
        polls_nxt     = polls_r;
        poll_en_nxt   = poll_en_r;
        ready_nxt     = ready_r;
        rsp_valid_nxt = 1'b0;
        rsp_owned_nxt = rsp_owned_r;
        rsp_flag_nxt  = rsp_flag_r;
        init_done_nxt = init_done_r;
        if (st_r != semh_pkg::SEMH_ST_IDLE && !busy_r) begin
            start_nxt = 1'b1;
            busy_nxt  = 1'b1;
            write_nxt = (st_r != semh_pkg::SEMH_ST_ACQR) &&
                        (st_r != semh_pkg::SEMH_ST_RD);
            wbit_nxt  = (st_r != semh_pkg::SEMH_ST_ACQW);
        end
        if (acc.done) begin
            busy_nxt = 1'b0;
        end
        case (st_r)
            semh_pkg::SEMH_ST_INIT: begin
                // free every token once; nothing in the device does it
                if (acc.done) begin
                    if (idx_r == `SEMH_LAST_IDX) begin
                        idx_nxt       = `SEMH_FIRST_IDX;
                        init_done_nxt = 1'b1;
                        rsp_valid_nxt = (op_r == semh_pkg::SEMH_OP_INIT);
                        rsp_owned_nxt = 1'b0;  // every token now free
                        rsp_flag_nxt  = 1'b1;
                        ready_nxt     = 1'b1;
                        st_nxt        = semh_pkg::SEMH_ST_IDLE;
                    end else begin
                        idx_nxt = 3'(idx_r + 3'h1);
                    end
                end
            end
            semh_pkg::SEMH_ST_IDLE: begin
                if (cmd_valid && ready_r) begin
                    ready_nxt   = 1'b0;
                    op_nxt      = cmd_op;
                    idx_nxt     = cmd_idx;
                    poll_en_nxt = cmd_poll;
                    polls_nxt   = `SEMH_POLL_RST;
                    case (cmd_op)
                        semh_pkg::SEMH_OP_ACQ: st_nxt = semh_pkg::SEMH_ST_ACQW;
                        semh_pkg::SEMH_OP_REL: st_nxt = semh_pkg::SEMH_ST_RELW;
                        semh_pkg::SEMH_OP_READ: st_nxt = semh_pkg::SEMH_ST_RD;
                        semh_pkg::SEMH_OP_INIT: begin
                            idx_nxt = `SEMH_FIRST_IDX;
                            st_nxt  = semh_pkg::SEMH_ST_INIT;
                        end
                        default: st_nxt = semh_pkg::SEMH_ST_IDLE;
                    endcase
                end
            end
            semh_pkg::SEMH_ST_ACQW: begin
                // write before read, so no gap between test and set
                if (acc.done) begin
                    st_nxt = semh_pkg::SEMH_ST_ACQR;
                end
            end
            semh_pkg::SEMH_ST_ACQR: begin
                if (acc.done) begin
                    if (won) begin
                        rsp_valid_nxt = 1'b1;
                        rsp_owned_nxt = 1'b1;
                        rsp_flag_nxt  = 1'b0;
                        ready_nxt     = 1'b1;
                        st_nxt        = semh_pkg::SEMH_ST_IDLE;
                    end else if (poll_en_r && polls_r != `SEMH_POLL_MAX) begin
                        // keep reading; the sequencer drops select between
                        polls_nxt = 4'(polls_r + 4'h1);
                    end else begin
                        // a stale pending zero could hand us the token later
                        st_nxt = semh_pkg::SEMH_ST_WDRAW;
                    end
                end
            end
            semh_pkg::SEMH_ST_WDRAW,
            semh_pkg::SEMH_ST_RELW: begin
                if (acc.done) begin
                    rsp_valid_nxt = 1'b1;
                    rsp_owned_nxt = 1'b0;
                    rsp_flag_nxt  = 1'b1;
                    ready_nxt     = 1'b1;
                    st_nxt        = semh_pkg::SEMH_ST_IDLE;
                end
            end
            semh_pkg::SEMH_ST_RD: begin
                if (acc.done) begin
                    rsp_valid_nxt = 1'b1;
                    rsp_owned_nxt = won;
                    rsp_flag_nxt  = acc.rdata[`SEMH_FLAG_BIT];
                    ready_nxt     = 1'b1;
                    st_nxt        = semh_pkg::SEMH_ST_IDLE;
                end
            end
            default: begin
                busy_nxt = 1'b0;
                st_nxt   = semh_pkg::SEMH_ST_INIT;
            end
        endcase
    end

    // registers; reset starts the power-up token clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r        <= semh_pkg::SEMH_ST_INIT;
            op_r        <= semh_pkg::SEMH_OP_ACQ;
            busy_r      <= 1'b0;
            start_r     <= 1'b0;
            write_r     <= 1'b0;
            wbit_r      <= 1'b1;
            idx_r       <= `SEMH_FIRST_IDX;
            polls_r     <= `SEMH_POLL_RST;
            poll_en_r   <= 1'b0;
            ready_r     <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_owned_r <= 1'b0;
            rsp_flag_r  <= 1'b1;
            init_done_r <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            op_r        <= op_nxt;
            busy_r      <= busy_nxt;
            start_r     <= start_nxt;
            write_r     <= write_nxt;
            wbit_r      <= wbit_nxt;
            idx_r       <= idx_nxt;
            polls_r     <= polls_nxt;
            poll_en_r   <= poll_en_nxt;
            ready_r     <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_owned_r <= rsp_owned_nxt;
            rsp_flag_r  <= rsp_flag_nxt;
            init_done_r <= init_done_nxt;
        end
    end

    assign acc.start = start_r;
    assign acc.write = write_r;
    assign acc.wbit  = wbit_r;
    assign acc.idx   = idx_r;
    assign cmd_ready = ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_owned = rsp_owned_r;
    assign rsp_flag  = rsp_flag_r;

    // pin timing of one access
    semh_pin_seq u_seq (
        .mclk    (mclk),
        .srst    (srst),
        .acc     (acc.seq),
        .semaphore_select_n (semaphore_select_n),
        .ce_n    (ce_n),
        .rw_n    (rw_n),
        .oe_n    (oe_n),
        .addr    (addr),
        .dq_i    (dq_i),
        .dq_o    (dq_o),
        .dq_oe_n (dq_oe_n)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    ram_off_a: assert property (!semaphore_select_n |-> ce_n)
        else $error("ram chip enable active during token access");
    acq_order_a: assert property (
        st_r == semh_pkg::SEMH_ST_ACQR && $past(st_r) != st_r
        |-> $past(st_r) == semh_pkg::SEMH_ST_ACQW)
        else $error("acquire read not preceded by request write");
    init_first_a: assert property (ready_r |-> init_done_r)
        else $error("commands accepted before token clear");
    withdraw_a: assert property (
        rsp_valid_r && !rsp_owned_r && op_r == semh_pkg::SEMH_OP_ACQ
        |-> $past(st_r) == semh_pkg::SEMH_ST_WDRAW)
        else $error("failed acquire reported without withdraw");
    release_one_a: assert property (
        start_r && st_r == semh_pkg::SEMH_ST_RELW |-> write_r && wbit_r)
        else $error("release is not a write of one");
    request_zero_a: assert property (
        start_r && st_r == semh_pkg::SEMH_ST_ACQW |=> ##[1:3] !rw_n
        ##0 dq_o[`SEMH_FLAG_BIT] == 1'b0)
        else $error("request write does not strobe a zero");

    won_c: cover property (rsp_valid_r && rsp_owned_r &&
        op_r == semh_pkg::SEMH_OP_ACQ);
    lost_c: cover property ($past(st_r) == semh_pkg::SEMH_ST_WDRAW &&
        rsp_valid_r);
    poll_won_c: cover property (rsp_valid_r && rsp_owned_r &&
        polls_r != `SEMH_POLL_RST);
    init_c: cover property ($rose(init_done_r));
endmodule // semh_ctrl

// ---- tb/semh_dev_model.sv ----
`include "semh_defines.svh"

// token device: host pins on one side, behavioural far port on the other
module semh_dev_model (
    input  wire logic                  semaphore_select_n,
    input  wire logic                  ce_n,
    input  wire logic                  rw_n,
    input  wire logic                  oe_n,
    input  wire logic [2:0]            addr,
    input  wire logic [`SEMH_DQ_W-1:0] dq_o,
    input  wire logic                  dq_oe_n,
    output logic [`SEMH_DQ_W-1:0]      dq_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // eight token latches, no reset: host requests start pending
    logic [7:0]            req_l = 8'h00;
    logic [7:0]            req_r = 8'hff;
    logic [7:0]            own_l = 8'h00;
    logic [7:0]            own_r = 8'h00;
    logic [`SEMH_DQ_W-1:0] out_r = 16'h0000;
    logic                  wr_end;
    logic                  rd_on;

    assign wr_end = semaphore_select_n | rw_n;
    assign rd_on  = ~(semaphore_select_n | oe_n);

    // owner releases first, then a free token goes to a request, host first
    task automatic settle(input int i);
        if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
        if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
        if (!own_l[i] && !own_r[i]) begin
            if (!req_l[i]) own_l[i] = 1'b1;
            else if (!req_r[i]) own_r[i] = 1'b1;
        end
    endtask

    // host write lands at the end of its strobe, bit zero only
    always @(posedge wr_end) begin
        if (ce_n === 1'b1 && dq_oe_n === 1'b0) begin
            req_l[addr] = dq_o[`SEMH_FLAG_BIT];
            settle(addr);
        end
    end

    // capture once per select; a held read never updates
    always @(posedge rd_on) begin
        out_r = {`SEMH_DQ_W{~own_l[addr]}};
    end

    // released bus shows the inverse so a stale value cannot pass
    assign dq_i = rd_on ? out_r : ~out_r;

    // far port access, used by the bench
    task automatic r_write(input int i, input logic b);
        req_r[i] = b;
        settle(i);
    endtask

    function automatic logic r_flag(input int i);
        return ~own_r[i];
    endfunction
endmodule // semh_dev_model

// ---- tb/tb_dual_port_semaphore_flags.sv ----
`include "semh_defines.svh"

module tb_dual_port_semaphore_flags;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  mclk = 1'b0;
    logic                  srst = 1'b1;
    logic                  cmd_valid = 1'b0;
    logic                  cmd_poll = 1'b0;
    logic [2:0]            cmd_idx = 3'h0;
    semh_pkg::semh_op_t    cmd_op = semh_pkg::SEMH_OP_READ;
    logic                  cmd_ready, rsp_valid, rsp_owned, rsp_flag;
    logic                  semaphore_select_n, ce_n, rw_n, oe_n, dq_oe_n;
    logic [2:0]            addr;
    logic [`SEMH_DQ_W-1:0] dq_i, dq_o;
    int                    fail_count = 0;
    int                    checked = 0;

    always #4 mclk = ~mclk;

    semh_ctrl dut (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_idx(cmd_idx), .cmd_poll(cmd_poll),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_owned(rsp_owned), .rsp_flag(rsp_flag),
        .semaphore_select_n(semaphore_select_n),
        .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .addr(addr), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe_n(dq_oe_n));

    semh_dev_model dev (.semaphore_select_n(semaphore_select_n),
        .ce_n(ce_n), .rw_n(rw_n),
        .oe_n(oe_n), .addr(addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
        .dq_i(dq_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // bounded wait at falling edges, a hang goes straight to the verdict
    task automatic wait_hi(input bit on_rsp);
        int n;
        n = 0;
        while ((on_rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
            @(negedge mclk);
            n++;
            if (n > 3000) begin
                fail_count++;
                give_verdict();
            end
        end
    endtask

    // one command, then its response and the idle ram enable are judged
    task automatic do_cmd(input semh_pkg::semh_op_t op, input logic [2:0] idx,
                          input logic poll, input logic eo, input logic ef);
        wait_hi(1'b0);
        cmd_op    = op;
        cmd_idx   = idx;
        cmd_poll  = poll;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        check(16'(cmd_ready), 16'h0000);
        wait_hi(1'b1);
        check(16'(rsp_owned), 16'(eo));
        check(16'(rsp_flag), 16'(ef));
        check(16'(cmd_ready), 16'h0001);
        check(16'(ce_n), 16'h0001);
        check(16'(semaphore_select_n), 16'h0001);
        check(16'({rw_n, oe_n, dq_oe_n}), 16'h0007);
    endtask

    // automatic init after reset leaves every token free
    task automatic t_free();
        for (int i = 0; i < 8; i++)
            do_cmd(semh_pkg::SEMH_OP_READ, 3'(i), 1'b0, 1'b0,
                   1'b1);
        check(16'(dev.req_l), 16'h00ff);
        $display("test free done");
    endtask

    // host takes token five, far side sees it held
    task automatic t_acquire();
        do_cmd(semh_pkg::SEMH_OP_ACQ, 3'h5, 1'b0, 1'b1, 1'b0);
        check(16'(dev.r_flag(5)), 16'h0001);
        check(16'(dev.own_l), 16'h0020);
        $display("test acquire done");
    endtask

    // far request waits, takes over on release, host loses and withdraws
    task automatic t_pass();
        dev.r_write(5, 1'b0);
        check(16'(dev.r_flag(5)), 16'h0001);
        do_cmd(semh_pkg::SEMH_OP_READ, 3'h5, 1'b0, 1'b1, 1'b0);
        do_cmd(semh_pkg::SEMH_OP_REL, 3'h5, 1'b0, 1'b0, 1'b1);
        check(16'(dev.r_flag(5)), 16'h0000);
        do_cmd(semh_pkg::SEMH_OP_ACQ, 3'h5, 1'b0, 1'b0, 1'b1);
        check(16'(dev.req_l[5]), 16'h0001);
        dev.r_write(5, 1'b1);
        check(16'(dev.r_flag(5)), 16'h0001);
        $display("test pass done");
    endtask

    // host polls a held token and wins once the far side lets go
    task automatic t_poll();
        dev.r_write(2, 1'b0);
        fork
            do_cmd(semh_pkg::SEMH_OP_ACQ, 3'h2, 1'b1, 1'b1,
                   1'b0);
            begin
                repeat (60) @(negedge mclk);
                dev.r_write(2, 1'b1);
            end
        join
        check(16'(dev.r_flag(2)), 16'h0001);
        do_cmd(semh_pkg::SEMH_OP_REL, 3'h2, 1'b0, 1'b0, 1'b1);
        $display("test poll done");
    endtask

    // init on demand frees a token the host still held
    task automatic t_reinit();
        do_cmd(semh_pkg::SEMH_OP_ACQ, 3'h1, 1'b0, 1'b1, 1'b0);
        do_cmd(semh_pkg::SEMH_OP_INIT, 3'h0, 1'b0, 1'b0, 1'b1);
        check(16'(dev.own_l), 16'h0000);
        do_cmd(semh_pkg::SEMH_OP_READ, 3'h1, 1'b0, 1'b0, 1'b1);
        $display("test reinit done");
    endtask

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        @(negedge mclk);
        check(16'(cmd_ready), 16'h0000);
        t_free();
        t_acquire();
        t_pass();
        t_poll();
        t_reinit();
        give_verdict();
    end
endmodule // tb_dual_port_semaphore_flags
